// *** src/mdio_pkg.sv ***
`default_nettype none
package mdio_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_INPUT_SEL   = 8'h00;
  localparam logic [7:0] ADDR_OUTPUT_SEL  = 8'h04;
  localparam logic [7:0] ADDR_OVL_DELAY   = 8'h08;
  localparam logic [7:0] ADDR_WARN_LEVEL  = 8'h0c;
  localparam logic [7:0] ADDR_SPEED_BAND  = 8'h10;
  localparam logic [7:0] ADDR_CONTROL     = 8'h14;
  localparam logic [7:0] ADDR_STATUS      = 8'h18;
  localparam logic [7:0] ADDR_MOTOR_IN    = 8'h1c;
  localparam logic [7:0] ADDR_RATIO       = 8'h20;

  // Input function codes.
  localparam logic [2:0] IN_UNUSED       = 3'h0;
  localparam logic [2:0] IN_FORWARD      = 3'h1;
  localparam logic [2:0] IN_REVERSE      = 3'h2;
  localparam logic [2:0] IN_SEL0         = 3'h3;
  localparam logic [2:0] IN_SEL1         = 3'h4;
  localparam logic [2:0] IN_ALARM_CLEAR  = 3'h5;
  localparam logic [2:0] IN_EXT_FAULT    = 3'h6;
  localparam logic [2:0] IN_HOLD_RELEASE = 3'h7;

  // Output function codes.
  localparam logic [2:0] OUT_UNUSED      = 3'h0;
  localparam logic [2:0] OUT_PRIMARY     = 3'h1;
  localparam logic [2:0] OUT_SPEED_PULSE = 3'h2;
  localparam logic [2:0] OUT_OVERLOAD    = 3'h3;
  localparam logic [2:0] OUT_MOTION      = 3'h4;
  localparam logic [2:0] OUT_ATTAINED    = 3'h5;
  localparam logic [2:0] OUT_WARNING     = 3'h6;

  // Field positions and factory values.
  localparam int          IN_SEL_W      = 3;
  localparam logic [8:0]  RST_INPUT_SEL = {IN_REVERSE, IN_SEL0, IN_FORWARD};
  localparam logic [5:0]  RST_OUT_SEL   = {OUT_PRIMARY, OUT_SPEED_PULSE};
  localparam logic [9:0]  RST_OVL_DELAY = 10'h12c;
  localparam logic [9:0]  MIN_OVL_DELAY = 10'h001;
  localparam logic [9:0]  MAX_OVL_DELAY = 10'h258;
  localparam logic [9:0]  CAP_OVL_DELAY = 10'h032;
  localparam logic [7:0]  RST_WARN      = 8'h78;
  localparam logic [7:0]  MIN_WARN      = 8'h32;
  localparam logic [7:0]  MAX_WARN      = 8'h78;
  localparam logic [8:0]  RST_BAND      = 9'h0c8;
  localparam logic [8:0]  MAX_BAND      = 9'h190;
  localparam logic [15:0] RATIO_UNITY   = 16'h0064;
  localparam int          PULSES_PER_REV = 30;
  localparam int          CTRL_INIT_BIT  = 0;
  localparam int          ALARM_CODE_EXT = 1;
  localparam int          ALARM_CODE_OVL = 2;

  // Timing.
  localparam int CLK_HZ          = 200000000;
  localparam int PULSE_WIDTH_NS  = 200000;
  localparam int PULSE_CYCLES    = PULSE_WIDTH_NS / 5;
  localparam int TENTH_SEC_CYC   = CLK_HZ / 10;
  localparam int DEBOUNCE_CYCLES = 16;
  localparam int INIT_CYCLES     = 64;

endpackage
`default_nettype wire

// *** src/mdio_debounce.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdio_debounce #(
  parameter int CYCLES = 16
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic raw_in,
  output logic      clean_out
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic [15:0] cnt;
    logic        clean;
  } mdio_deb_s;

  mdio_deb_s st_q;
  mdio_deb_s st_d;

  // Two-stage synchroniser, then a level must stay stable CYCLES clocks.
  always_comb begin
    st_d    = st_q;
    st_d.s1 = raw_in;
    st_d.s2 = st_q.s1;
    if (st_q.s2 == st_q.clean) begin
      st_d.cnt = 16'h0000;
    end else if (st_q.cnt == 16'(CYCLES - 1)) begin
      st_d.cnt   = 16'h0000;
      st_d.clean = st_q.s2;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign clean_out = st_q.clean;

endmodule
`default_nettype wire

// *** src/mdio_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdio_core #(
  parameter int TENTH_CYCLES = mdio_pkg::TENTH_SEC_CYC,
  parameter int DEB_CYCLES   = mdio_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [2:0]  input_terminal,
  input  wire logic        shaft_rev_tick,
  input  wire logic        motor_rotating,
  output logic [1:0]       output_terminal,
  output logic             run_enable,
  output logic             run_reverse,
  output logic             instant_stop,
  output logic [1:0]       data_select,
  output logic             hold_enable
);

  // Motor-side quantities are carried in software-written measurement fields:
  // load factor, measured speed and a shaft-locked/over-region flag; the set speed is never written and stays zero.
  typedef struct packed {
    logic        aw_hold;
    logic [7:0]  awaddr;
    logic        w_hold;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [8:0]  in_sel;
    logic [5:0]  out_sel;
    logic [9:0]  ovl_delay;
    logic [7:0]  warn_level;
    logic [8:0]  band;
    logic [15:0] inc_ratio;
    logic [15:0] red_ratio;
    logic [7:0]  load_pct;
    logic [12:0] meas_speed;
    logic [12:0] set_speed;
    logic        heavy_load;
    logic        hold_cfg;
    logic        alarm;
    logic [1:0]  alarm_code;
    logic [9:0]  ovl_tenths;
    logic [31:0] tenth_cnt;
    logic [5:0]  pulse_slot;
    logic [16:0] pulse_cnt;
    logic        pulse_out;
    logic [7:0]  init_cnt;
    logic [1:0]  out_term;
    logic        run_en;
    logic        run_rev;
    logic        stop_now;
    logic [1:0]  dsel;
    logic        hold_en;
  } mdio_core_s;

  mdio_core_s st_q;
  mdio_core_s st_d;

  logic [2:0] term_clean;
  logic       forward_run_in;
  logic       reverse_run_in;
  logic       sel0;
  logic       sel1;
  logic       aclr;
  logic       ext_ok;
  logic       hrel;
  logic       any_ext;
  logic       limited_load;
  logic       warn_cond;
  logic       ovl_fault;
  logic       attained;
  logic [9:0] ovl_limit;
  logic [12:0] spd_diff;
  logic [6:0] func_vec;

  // Debounce each input terminal.
  // synchronise and debounce
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_deb
      mdio_debounce #(
        .CYCLES (DEB_CYCLES)
      ) u_deb (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .raw_in    (input_terminal[gi]),
        .clean_out (term_clean[gi])
      );
    end
  endgenerate

  // Map terminals onto input functions.
  always_comb begin
    forward_run_in     = 1'b0;
    reverse_run_in     = 1'b0;
    sel0    = 1'b0;
    sel1    = 1'b0;
    aclr    = 1'b0;
    any_ext = 1'b0;
    ext_ok  = 1'b1;
    hrel    = 1'b0;
    for (int i = 0; i < 3; i++) begin
      case (st_q.in_sel[i*mdio_pkg::IN_SEL_W +: mdio_pkg::IN_SEL_W])
        mdio_pkg::IN_FORWARD:      forward_run_in  = forward_run_in | term_clean[i];
        mdio_pkg::IN_REVERSE:      reverse_run_in  = reverse_run_in | term_clean[i];
        mdio_pkg::IN_SEL0:         sel0 = sel0 | term_clean[i];
        mdio_pkg::IN_SEL1:         sel1 = sel1 | term_clean[i];
        mdio_pkg::IN_ALARM_CLEAR:  aclr = aclr | term_clean[i];
        mdio_pkg::IN_EXT_FAULT: begin
          any_ext = 1'b1;
          ext_ok  = ext_ok & term_clean[i];
        end
        mdio_pkg::IN_HOLD_RELEASE: hrel = hrel | term_clean[i];
        default: begin
        end
      endcase
    end
    // An active-low fault acts when any of its terminals opens.
    if (!any_ext) begin
      ext_ok = 1'b1;
    end
  end

  // Load and speed monitors.
  always_comb begin
    warn_cond    = st_q.load_pct > st_q.warn_level;
    limited_load = st_q.load_pct > 8'h64;
    if (st_q.heavy_load && st_q.ovl_delay > mdio_pkg::CAP_OVL_DELAY) begin
      ovl_limit = mdio_pkg::CAP_OVL_DELAY;
    end else begin
      ovl_limit = st_q.ovl_delay;
    end
    spd_diff = (st_q.meas_speed > st_q.set_speed) ? st_q.meas_speed - st_q.set_speed
                                                  : st_q.set_speed - st_q.meas_speed;
    attained  = motor_rotating && (spd_diff <= 13'(st_q.band));
    ovl_fault = st_q.alarm && (st_q.alarm_code == 2'(mdio_pkg::ALARM_CODE_OVL));
    func_vec[0] = !st_q.alarm;
    func_vec[1] = st_q.pulse_out;
    func_vec[2] = !(warn_cond || ovl_fault);
    func_vec[3] = st_q.run_en;
    func_vec[4] = attained;
    func_vec[5] = warn_cond;
    func_vec[6] = 1'b0;
  end

  // Next-state logic: bus slave, configuration, control and outputs.
  always_comb begin
    st_d = st_q;
    if (s_axi_awvalid && !st_q.aw_hold) begin
      st_d.aw_hold = 1'b1;
      st_d.awaddr  = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_q.w_hold) begin
      st_d.w_hold = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Commit a write once address and data are both held.
    if (st_q.aw_hold && st_q.w_hold && !st_q.bvalid) begin
      st_d.aw_hold = 1'b0;
      st_d.w_hold  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = 2'b00;
      case (st_q.awaddr)
        mdio_pkg::ADDR_INPUT_SEL:  st_d.in_sel  = st_q.wdata[8:0];
        mdio_pkg::ADDR_OUTPUT_SEL: st_d.out_sel = st_q.wdata[5:0];
        mdio_pkg::ADDR_OVL_DELAY: begin
          if (st_q.wdata[9:0] >= mdio_pkg::MIN_OVL_DELAY && st_q.wdata[9:0] <= mdio_pkg::MAX_OVL_DELAY) begin
            st_d.ovl_delay = st_q.wdata[9:0];
          end else begin
            st_d.bresp = 2'b10;
          end
        end
        mdio_pkg::ADDR_WARN_LEVEL: begin
          if (st_q.wdata[7:0] >= mdio_pkg::MIN_WARN && st_q.wdata[7:0] <= mdio_pkg::MAX_WARN) begin
            st_d.warn_level = st_q.wdata[7:0];
          end else begin
            st_d.bresp = 2'b10;
          end
        end
        mdio_pkg::ADDR_SPEED_BAND: begin
          if (st_q.wdata[8:0] <= mdio_pkg::MAX_BAND) begin
            st_d.band = st_q.wdata[8:0];
          end else begin
            st_d.bresp = 2'b10;
          end
        end
        mdio_pkg::ADDR_CONTROL: begin
          st_d.hold_cfg = st_q.wdata[1];
          if (st_q.wdata[mdio_pkg::CTRL_INIT_BIT]) begin
            st_d.init_cnt = 8'(mdio_pkg::INIT_CYCLES);
          end
        end
        mdio_pkg::ADDR_MOTOR_IN: begin
          st_d.load_pct   = st_q.wdata[7:0];
          st_d.meas_speed = st_q.wdata[20:8];
          st_d.heavy_load = st_q.wdata[31];
        end
        mdio_pkg::ADDR_RATIO: begin
          st_d.inc_ratio = st_q.wdata[15:0];
          st_d.red_ratio = st_q.wdata[31:16];
        end
        default: st_d.bresp = 2'b10;
      endcase
    end
    // Read channel answers one cycle after the address is taken.
    if (s_axi_rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = 2'b00;
      st_d.rdata  = 32'h00000000;
      case (s_axi_araddr[7:0])
        mdio_pkg::ADDR_INPUT_SEL:  st_d.rdata[8:0] = st_q.in_sel;
        mdio_pkg::ADDR_OUTPUT_SEL: st_d.rdata[5:0] = st_q.out_sel;
        mdio_pkg::ADDR_OVL_DELAY:  st_d.rdata[9:0] = st_q.ovl_delay;
        mdio_pkg::ADDR_WARN_LEVEL: st_d.rdata[7:0] = st_q.warn_level;
        mdio_pkg::ADDR_SPEED_BAND: st_d.rdata[8:0] = st_q.band;
        mdio_pkg::ADDR_CONTROL:    st_d.rdata[1:0] = {st_q.hold_cfg, st_q.init_cnt != 8'h00};
        mdio_pkg::ADDR_STATUS: begin
          st_d.rdata[31:16] = (st_q.inc_ratio == mdio_pkg::RATIO_UNITY) ? st_q.red_ratio : st_q.inc_ratio;
          st_d.rdata[8:0]   = {st_q.alarm_code, st_q.alarm, warn_cond, attained,
                               st_q.run_en, st_q.hold_en, term_clean[1:0]};
        end
        mdio_pkg::ADDR_MOTOR_IN:   st_d.rdata = {st_q.heavy_load, 10'h000, st_q.meas_speed, st_q.load_pct};
        mdio_pkg::ADDR_RATIO:      st_d.rdata = {st_q.red_ratio, st_q.inc_ratio};
        default:                   st_d.rresp = 2'b10;
      endcase
    end

    if (st_q.init_cnt != 8'h00) begin
      st_d.init_cnt   = st_q.init_cnt - 8'h01;
      st_d.in_sel     = mdio_pkg::RST_INPUT_SEL;
      st_d.out_sel    = mdio_pkg::RST_OUT_SEL;
      st_d.ovl_delay  = mdio_pkg::RST_OVL_DELAY;
      st_d.warn_level = mdio_pkg::RST_WARN;
      st_d.band       = mdio_pkg::RST_BAND;
      st_d.inc_ratio  = mdio_pkg::RATIO_UNITY;
      st_d.red_ratio  = mdio_pkg::RATIO_UNITY;
      st_d.hold_cfg   = 1'b0;
    end

    // Overload timer counts tenths of a second while loaded.
    if (limited_load || st_q.heavy_load) begin
      if (st_q.tenth_cnt == 32'(TENTH_CYCLES - 1)) begin
        st_d.tenth_cnt = 32'h00000000;
        if (st_q.ovl_tenths < ovl_limit) begin
          st_d.ovl_tenths = st_q.ovl_tenths + 10'h001;
        end
      end else begin
        st_d.tenth_cnt = st_q.tenth_cnt + 32'h00000001;
      end
    end else begin
      st_d.tenth_cnt  = 32'h00000000;
      st_d.ovl_tenths = 10'h000;
    end

    if (aclr) begin
      st_d.alarm      = 1'b0;
      st_d.alarm_code = 2'b00;
    end
    if (st_q.ovl_tenths >= ovl_limit && (limited_load || st_q.heavy_load)) begin
      st_d.alarm      = 1'b1;
      st_d.alarm_code = 2'(mdio_pkg::ALARM_CODE_OVL);
    end
    if (!ext_ok) begin
      st_d.alarm      = 1'b1;
      st_d.alarm_code = 2'(mdio_pkg::ALARM_CODE_EXT);
    end

    st_d.run_en   = (forward_run_in ^ reverse_run_in) && !st_d.alarm;
    st_d.run_rev  = reverse_run_in && !forward_run_in;
    st_d.stop_now = (forward_run_in && reverse_run_in) || !ext_ok || st_d.alarm;
    st_d.dsel     = {sel1, sel0};
    st_d.hold_en  = st_q.hold_cfg && !hrel && !motor_rotating;

    if (shaft_rev_tick) begin
      st_d.pulse_slot = 6'(mdio_pkg::PULSES_PER_REV);
    end
    // The period counter needs 17 bits: two pulse widths exceed a 16-bit range.
    // Loading one less than the period keeps high and low phases equally long.
    if (st_q.pulse_cnt != 17'h00000) begin
      st_d.pulse_cnt = st_q.pulse_cnt - 17'h00001;
      st_d.pulse_out = (st_q.pulse_cnt > 17'(mdio_pkg::PULSE_CYCLES));
    end else if (st_q.pulse_slot != 6'h00 && !shaft_rev_tick) begin
      st_d.pulse_slot = st_q.pulse_slot - 6'h01;
      st_d.pulse_cnt  = 17'(2 * mdio_pkg::PULSE_CYCLES - 1);
      st_d.pulse_out  = 1'b1;
    end else begin
      st_d.pulse_out = 1'b0;
    end

    for (int t = 0; t < 2; t++) begin
      case (st_q.out_sel[t*3 +: 3])
        mdio_pkg::OUT_UNUSED: st_d.out_term[t] = 1'b0;
        default:              st_d.out_term[t] = func_vec[3'(st_q.out_sel[t*3 +: 3] - 3'h1)];
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q            <= '0;
      st_q.in_sel     <= mdio_pkg::RST_INPUT_SEL;
      st_q.out_sel    <= mdio_pkg::RST_OUT_SEL;
      st_q.ovl_delay  <= mdio_pkg::RST_OVL_DELAY;
      st_q.warn_level <= mdio_pkg::RST_WARN;
      st_q.band       <= mdio_pkg::RST_BAND;
      st_q.inc_ratio  <= mdio_pkg::RATIO_UNITY;
      st_q.red_ratio  <= mdio_pkg::RATIO_UNITY;
    end else begin
      st_q <= st_d;
    end
  end

  // Bus handshakes and terminal outputs.
  assign s_axi_awready   = !st_q.aw_hold;
  assign s_axi_wready    = !st_q.w_hold;
  assign s_axi_bvalid    = st_q.bvalid;
  assign s_axi_bresp     = st_q.bresp;
  assign s_axi_arready   = !st_q.rvalid;
  assign s_axi_rvalid    = st_q.rvalid;
  assign s_axi_rdata     = st_q.rdata;
  assign s_axi_rresp     = st_q.rresp;
  assign output_terminal = st_q.out_term;
  assign run_enable      = st_q.run_en;
  assign run_reverse     = st_q.run_rev;
  assign instant_stop    = st_q.stop_now;
  assign data_select     = st_q.dsel;
  assign hold_enable     = st_q.hold_en;

endmodule
`default_nettype wire

// *** testbench/mdio_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdio_properties #(
  parameter int DEB_CYCLES = 16
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [2:0] input_terminal,
  input wire logic [1:0] output_terminal,
  input wire logic       run_enable,
  input wire logic       run_reverse,
  input wire logic       instant_stop,
  input wire logic [1:0] data_select
);
  logic [2:0] term_q;
  logic [7:0] quiet_q;
  // Counts the cycles since the input terminals last changed.
  always_ff @(posedge aclk) begin
    term_q <= input_terminal;
    if (!aresetn || input_terminal != term_q) begin
      quiet_q <= 8'h00;
    end else if (quiet_q != 8'hff) begin
      quiet_q <= quiet_q + 8'h01;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_stop_no_run;
    instant_stop |-> !run_enable;
  endproperty
  a_stop_no_run: assert property (p_stop_no_run) else $error("run during stop");
  property p_stop_holds;
    $rose(instant_stop) |-> (!run_enable) [*4];
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stop not held");
  property p_reset_defaults;
    $rose(aresetn) |-> ##2 output_terminal == 2'h2 && !run_enable && !instant_stop;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad levels after reset");
  property p_run_settled;
    $rose(run_enable) |-> quiet_q >= 8'(DEB_CYCLES);
  endproperty
  a_run_settled: assert property (p_run_settled) else $error("run before debounce");
  property p_dir_settled;
    $changed(run_reverse) |-> quiet_q >= 8'(DEB_CYCLES);
  endproperty
  a_dir_settled: assert property (p_dir_settled) else $error("direction before debounce");
  property p_dir_fixed;
    $rose(run_enable) |=> $stable(run_reverse) [*4];
  endproperty
  a_dir_fixed: assert property (p_dir_fixed) else $error("direction moved at start");
  property p_select_settled;
    $changed(data_select) |-> quiet_q >= 8'(DEB_CYCLES) && quiet_q <= 8'h28;
  endproperty
  a_select_settled: assert property (p_select_settled) else $error("select timing");
  property p_stop_settled;
    $rose(instant_stop) |-> quiet_q >= 8'(DEB_CYCLES);
  endproperty
  a_stop_settled: assert property (p_stop_settled) else $error("stop before debounce");
endmodule
bind mdio_core mdio_properties #(.DEB_CYCLES(DEB_CYCLES)) i_mdio_properties (.aclk(aclk), .aresetn(aresetn),
  .input_terminal(input_terminal), .output_terminal(output_terminal), .run_enable(run_enable),
  .run_reverse(run_reverse), .instant_stop(instant_stop), .data_select(data_select));
`default_nettype wire

// *** testbench/mdio_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdio_ctrl_model (
  input  wire logic  aclk,
  input  wire logic  run_enable,
  input  wire logic  instant_stop,
  output logic [2:0] input_terminal,
  output logic       shaft_rev_tick,
  output logic       motor_rotating
);
  // Terminals and motor feedback start idle.
  initial begin
    input_terminal = 3'h0;
    shaft_rev_tick = 1'b0;
    motor_rotating = 1'b0;
  end
  // The motor turns one cycle after the driver lets it run.
  always @(posedge aclk) begin
    motor_rotating <= run_enable && !instant_stop;
  end
  // Sets the terminal levels just after an edge.
  task automatic set_term(input logic [2:0] v);
    @(posedge aclk);
    input_terminal <= v;
  endtask
  // Gives one revolution tick of one cycle.
  task automatic tick();
    @(posedge aclk);
    shaft_rev_tick <= 1'b1;
    @(posedge aclk);
    shaft_rev_tick <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** testbench/mdio_core_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdio_core_tb_top;
  logic        aclk, aresetn, awv, wv, bv, br, arv, arr, rv, rr, awr, wr_r, tick, rot, run, reverse_run_in, stp, hold;
  logic [31:0] awa, wd, ara, rdat;
  logic [1:0]  bresp, rresp, ot, ds;
  logic [2:0]  term;
  wire  [7:0]  pins = {ot, run, reverse_run_in, stp, ds, hold};
  int          mismatches, compares, cycles, n;
  mdio_core #(.TENTH_CYCLES(10), .DEB_CYCLES(16)) i_mdio_core (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .input_terminal(term), .shaft_rev_tick(tick), .motor_rotating(rot),
    .output_terminal(ot), .run_enable(run), .run_reverse(reverse_run_in), .instant_stop(stp), .data_select(ds),
    .hold_enable(hold));
  mdio_ctrl_model i_mdio_ctrl_model (.aclk(aclk), .run_enable(run), .instant_stop(stp),
    .input_terminal(term), .shaft_rev_tick(tick), .motor_rotating(rot));
  // Clock of 5 ns period.
  always #2.5 aclk = ~aclk;
  // Cuts a hung run short.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    awa <= {24'h0, a};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 100);
    chk("bvalid", 32'h1, {31'h0, bv});
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    br <= 1'b0;
  endtask
  task automatic rck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    ara <= {24'h0, a};
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 100);
    chk("rvalid", 32'h1, {31'h0, rv});
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    chk("rdata", e, rdat & m);
    rr <= 1'b0;
  endtask
  // Sets the terminals and waits past synchroniser and debounce.
  task automatic tm(input logic [2:0] v);
    i_mdio_ctrl_model.set_term(v);
    repeat (30) @(posedge aclk);
  endtask
  task automatic pc(input logic [7:0] m, input logic [7:0] e);
    chk("pins", {24'h0, e}, {24'h0, pins & m});
  endtask
  task automatic rst();
    i_mdio_ctrl_model.set_term(3'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic att(input logic [31:0] band, input logic [31:0] spd, input logic [7:0] e);
    wr(mdio_pkg::ADDR_SPEED_BAND, band);
    wr(mdio_pkg::ADDR_MOTOR_IN, spd << 8);
    repeat (5) @(posedge aclk);
    pc(8'h40, e);
  endtask
  // Main sequence of tests.
  initial begin
    {aclk, aresetn, awv, wv, br, arv, rr, awa, wd, ara} = '0;
    // Reset stays low for two edges, then three edges pass before the first request.
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rck(mdio_pkg::ADDR_INPUT_SEL, 32'h1ff, 32'(mdio_pkg::RST_INPUT_SEL));
    rck(mdio_pkg::ADDR_OUTPUT_SEL, 32'h3f, 32'(mdio_pkg::RST_OUT_SEL));
    rck(mdio_pkg::ADDR_OVL_DELAY, 32'h3ff, 32'(mdio_pkg::RST_OVL_DELAY));
    rck(mdio_pkg::ADDR_WARN_LEVEL, 32'hff, 32'(mdio_pkg::RST_WARN));
    rck(mdio_pkg::ADDR_SPEED_BAND, 32'h1ff, 32'(mdio_pkg::RST_BAND));
    pc(8'hff, 8'h80);
    wr(8'h40, 32'h0, 2'h2);
    rck(8'h40, 32'h0, 32'h0, 2'h2);
    wr(mdio_pkg::ADDR_WARN_LEVEL, 32'h31, 2'h2);
    wr(mdio_pkg::ADDR_OVL_DELAY, 32'h0, 2'h2);
    wr(mdio_pkg::ADDR_SPEED_BAND, 32'h191, 2'h2);
    rck(mdio_pkg::ADDR_WARN_LEVEL, 32'hff, 32'h78);
    $display("test defaults done");
    wr(mdio_pkg::ADDR_OUTPUT_SEL, 32'h20);
    tm(3'h1);
    pc(8'hff, 8'ha0);
    tm(3'h4);
    pc(8'hff, 8'hb0);
    tm(3'h5);
    pc(8'hef, 8'h08);
    tm(3'h0);
    wr(mdio_pkg::ADDR_INPUT_SEL, 32'h89);
    tm(3'h2);
    pc(8'hff, 8'ha0);
    tm(3'h0);
    pc(8'hff, 8'h00);
    $display("test run done");
    wr(mdio_pkg::ADDR_INPUT_SEL, 32'h1e3);
    wr(mdio_pkg::ADDR_CONTROL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      tm(3'(i));
      pc(8'hff, {5'h0, 2'(i), 1'b1});
    end
    tm(3'h4);
    pc(8'hff, 8'h00);
    $display("test select done");
    tm(3'h1);
    wr(mdio_pkg::ADDR_OUTPUT_SEL, 32'h08);
    wr(mdio_pkg::ADDR_INPUT_SEL, 32'h06e);
    tm(3'h5);
    pc(8'he8, 8'ha0);
    tm(3'h4);
    pc(8'he8, 8'h08);
    rck(mdio_pkg::ADDR_STATUS, 32'h1c0, 32'h0c0);
    tm(3'h1);
    pc(8'hc0, 8'h00);
    tm(3'h3);
    pc(8'he0, 8'h80);
    rst();
    $display("test fault done");
    wr(mdio_pkg::ADDR_INPUT_SEL, 32'h0);
    tm(3'h7);
    pc(8'h3f, 8'h00);
    tm(3'h0);
    wr(mdio_pkg::ADDR_OUTPUT_SEL, 32'h1e);
    wr(mdio_pkg::ADDR_WARN_LEVEL, 32'h32);
    wr(mdio_pkg::ADDR_MOTOR_IN, 32'h3c);
    repeat (5) @(posedge aclk);
    pc(8'hc0, 8'h40);
    wr(mdio_pkg::ADDR_MOTOR_IN, 32'h28);
    repeat (5) @(posedge aclk);
    pc(8'hc0, 8'h80);
    wr(mdio_pkg::ADDR_OVL_DELAY, 32'h1);
    wr(mdio_pkg::ADDR_MOTOR_IN, 32'h6e);
    rck(mdio_pkg::ADDR_STATUS, 32'h40, 32'h0);
    repeat (20) @(posedge aclk);
    rck(mdio_pkg::ADDR_STATUS, 32'h1c0, 32'h140);
    pc(8'h80, 8'h00);
    rst();
    wr(mdio_pkg::ADDR_OVL_DELAY, 32'h258);
    wr(mdio_pkg::ADDR_MOTOR_IN, 32'h8000006e);
    repeat (300) @(posedge aclk);
    rck(mdio_pkg::ADDR_STATUS, 32'h40, 32'h0);
    repeat (250) @(posedge aclk);
    rck(mdio_pkg::ADDR_STATUS, 32'h40, 32'h40);
    rst();
    $display("test overload done");
    wr(mdio_pkg::ADDR_OUTPUT_SEL, 32'h2d);
    // Attainment is only shown while the motor turns, so forward run is applied first.
    tm(3'h1);
    att(32'd200, 32'd150, 8'h40);
    att(32'd200, 32'd201, 8'h00);
    att(32'd200, 32'd200, 8'h40);
    att(32'd0, 32'd1, 8'h00);
    rst();
    $display("test attained done");
    i_mdio_ctrl_model.tick();
    for (n = 0; ot[0] !== 1'b1 && n < 200; n++) @(posedge aclk);
    for (n = 0; ot[0] === 1'b1 && n < 50000; n++) @(posedge aclk);
    chk("width", 32'(mdio_pkg::PULSE_CYCLES), n);
    rst();
    $display("test pulse done");
    wr(mdio_pkg::ADDR_WARN_LEVEL, 32'h40);
    wr(mdio_pkg::ADDR_CONTROL, 32'h1);
    rck(mdio_pkg::ADDR_CONTROL, 32'h1, 32'h1);
    repeat (70) @(posedge aclk);
    rck(mdio_pkg::ADDR_CONTROL, 32'h1, 32'h0);
    rck(mdio_pkg::ADDR_WARN_LEVEL, 32'hff, 32'h78);
    wr(mdio_pkg::ADDR_RATIO, 32'h00fa0064);
    rck(mdio_pkg::ADDR_STATUS, 32'hffff0000, 32'h00fa0000);
    wr(mdio_pkg::ADDR_RATIO, 32'h00fa0096);
    rck(mdio_pkg::ADDR_STATUS, 32'hffff0000, 32'h00960000);
    $display("test init done");
    end_sim();
  end
endmodule
`default_nettype wire
